// [swu_cfg.svh]
// Constants, timing counts and frame bytes for the single-wire bit mapper.
// How it works
// - Host holds line low 90 us for reset, 50 ms for power reset.
// - Sensor classifies low pulses by their length.
// - Host starts read slot low, then releases.
// - Sensor holds low for zero, releases for one.
// - Both only pull low, idle undriven.
// - Same protocol in either power mode.
// - UART transmit via open-drain buffer, echo received.
// - Baud makes 00h a reset-length pulse.
// - Start bit makes each slot's falling edge.
// - Send FFh for one, C0h for zero.
// - Host discards echoes of writes and resets.
// - Read sends FFh; FFh echo one, F0h zero.
`ifndef SWU_CFG_SVH
`define SWU_CFG_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SWU_CLK_NS 50
`define SWU_BIT_NS 10000
`define SWU_BIT_CYC (`SWU_BIT_NS / `SWU_CLK_NS)
`define SWU_POR_MS 50
`define SWU_POR_CYC (`SWU_POR_MS * 1000000 / `SWU_CLK_NS)
`define SWU_ONE_MAX_NS 30000
`define SWU_ONE_MAX_CYC (`SWU_ONE_MAX_NS / `SWU_CLK_NS)
`define SWU_RST_MIN_NS 80000
`define SWU_RST_MIN_CYC ((`SWU_RST_MIN_NS + `SWU_CLK_NS - 1) / `SWU_CLK_NS)
`define SWU_HOLD_NS 50000
`define SWU_HOLD_CYC ((`SWU_HOLD_NS + `SWU_CLK_NS - 1) / `SWU_CLK_NS)

// ----------------------------------------------------------------
// Frame bytes
// ----------------------------------------------------------------
`define SWU_BYTE_RESET 8'h00
`define SWU_BYTE_ONE 8'hff
`define SWU_BYTE_ZERO 8'hc0
`define SWU_ECHO_ONE 8'hff
`define SWU_ECHO_ZERO 8'hf0
`define SWU_FRAME_BITS 4'ha
`define SWU_FIFO_DEPTH 16
`define SWU_CMD_W 3

`endif

// [swu_pkg.sv]
// Types shared by both ends of the single-wire bit mapper.
package swu_pkg;

  typedef enum logic [2:0] {cmd_reset, cmd_write0, cmd_write1, cmd_read, cmd_power} swu_cmd_e;

  typedef enum logic [1:0] {kind_reset, kind_one, kind_zero, kind_read} swu_kind_e;

endpackage

// [swu_if.sv]
// Shared data line between host and sensor, with external pullup.
`timescale 1ns/1ns
`default_nettype none
interface swu_if;
  logic host_out;
  logic host_oe;
  logic dev_out;
  logic dev_oe;
  logic shared_data_line;

  // Pullup holds the line high unless a party drives it low.
  assign shared_data_line = !((host_oe && !host_out) || (dev_oe && !dev_out));

  modport host (output host_out, output host_oe, input shared_data_line);
  modport device (output dev_out, output dev_oe, input shared_data_line);
endinterface
`default_nettype wire

// [swu_fifo.sv]
// Command FIFO with valid and ready on both sides.
`timescale 1ns/1ns
`default_nettype none
module swu_fifo #(
  parameter int W = 3,
  parameter int D = 16
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;

  assign in_ready  = (wr_ptr - rd_ptr) != (AW + 1)'(D);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge sys_clk)
  begin
    if (in_valid && in_ready)
    begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
    end
    else if (in_valid && in_ready)
    begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rd_ptr <= '0;
    end
    else if (out_valid && out_ready)
    begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule
`default_nettype wire

// [swu_device.sv]
// Sensor end: decodes host low pulses and answers read slots.
`timescale 1ns/1ns
`default_nettype none
`include "swu_cfg.svh"
module swu_device
  import swu_pkg::*;
(
  input  wire logic  sys_clk,
  input  wire logic  rst,
  swu_if.device      bus,
  input  wire logic  tx_valid,
  output logic       tx_ready,
  input  wire logic  tx_bit,
  output logic       ev_valid,
  output swu_kind_e  ev_kind
);
  localparam logic [10:0] ONE_MAX = 11'(`SWU_ONE_MAX_CYC);
  localparam logic [10:0] RST_MIN = 11'(`SWU_RST_MIN_CYC);
  localparam logic [10:0] HOLD    = 11'(`SWU_HOLD_CYC);

  logic        line_m;
  logic        line_s;
  logic        line_d;
  logic        fall;
  logic        rise;
  logic        armed;
  logic        arm_bit;
  logic        slot_read;
  logic [10:0] hold_cnt;
  logic [10:0] low_cnt;

  // ----------------------------------------------------------------
  // Line sampling
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      line_m <= 1'b1;
      line_s <= 1'b1;
      line_d <= 1'b1;
    end
    else
    begin
      line_m <= bus.shared_data_line;
      line_s <= line_m;
      line_d <= line_s;
    end
  end

  assign fall = line_d && !line_s;
  assign rise = !line_d && line_s;

  // ----------------------------------------------------------------
  // Read slot answer
  // ----------------------------------------------------------------
  assign tx_ready    = !armed;
  assign bus.dev_out = 1'b0;
  assign bus.dev_oe  = hold_cnt != 11'h000;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      armed   <= 1'b0;
      arm_bit <= 1'b1;
    end
    else if (tx_valid && !armed)
    begin
      armed   <= 1'b1;
      arm_bit <= tx_bit;
    end
    else if (fall)
    begin
      armed <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      hold_cnt <= 11'h000;
    end
    else if (fall && armed && !arm_bit)
    begin
      hold_cnt <= HOLD;
    end
    else if (hold_cnt != 11'h000)
    begin
      hold_cnt <= hold_cnt - 11'h001;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      slot_read <= 1'b0;
    end
    else if (fall)
    begin
      slot_read <= armed;
    end
  end

  // ----------------------------------------------------------------
  // Low pulse timing and classification
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      low_cnt <= 11'h000;
    end
    else if (fall)
    begin
      low_cnt <= 11'h001;
    end
    else if (!line_s && low_cnt != 11'h7ff)
    begin
      low_cnt <= low_cnt + 11'h001;
    end
  end

  // Decoding does not depend on how the sensor is powered.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ev_valid <= 1'b0;
      ev_kind  <= kind_reset;
    end
    else
    begin
      ev_valid <= rise;
      if (rise)
      begin
        if (low_cnt >= RST_MIN)
        begin
          ev_kind <= kind_reset;
        end
        else if (slot_read)
        begin
          ev_kind <= kind_read;
        end
        else if (low_cnt <= ONE_MAX)
        begin
          ev_kind <= kind_one;
        end
        else
        begin
          ev_kind <= kind_zero;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [swu_host.sv]
// Host end: UART-style framing that maps commands onto line slots.
`timescale 1ns/1ns
`default_nettype none
`include "swu_cfg.svh"
module swu_host
  import swu_pkg::*;
#(
  parameter int POR_CYC = `SWU_POR_CYC
) (
  input  wire logic  sys_clk,
  input  wire logic  rst,
  input  wire logic  cmd_valid,
  output logic       cmd_ready,
  input  wire swu_cmd_e cmd,
  swu_if.host        bus,
  output logic       busy,
  output logic       done,
  output logic       rd_valid,
  output logic       rd_bit,
  output logic       rd_err
);
  localparam logic [7:0] BIT_LAST = 8'(`SWU_BIT_CYC - 1);
  localparam logic [7:0] BIT_HALF = 8'(`SWU_BIT_CYC / 2);

  typedef enum logic [1:0] {st_idle, st_frame, st_power} swu_state_e;

  swu_state_e  state;
  logic        q_valid;
  logic        q_take;
  logic [2:0]  q_data;
  swu_cmd_e    cur;
  logic [7:0]  baud_cnt;
  logic        baud_tick;
  logic [3:0]  bits_left;
  logic [9:0]  tx_sh;
  logic        tx_level;
  logic [19:0] por_cnt;
  logic        line_m;
  logic        line_s;
  logic        line_d;
  logic        rx_busy;
  logic [7:0]  rx_cnt;
  logic [3:0]  rx_idx;
  logic [8:0]  rx_sh;
  logic [7:0]  echo;
  logic        echo_seen;

  // ----------------------------------------------------------------
  // Command queue
  // ----------------------------------------------------------------
  swu_fifo #(
    .W (`SWU_CMD_W),
    .D (`SWU_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (cmd_valid),
    .in_ready  (cmd_ready),
    .in_data   (cmd),
    .out_valid (q_valid),
    .out_ready (q_take),
    .out_data  (q_data)
  );

  assign q_take = (state == st_idle);
  assign busy   = (state != st_idle);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state <= st_idle;
      cur   <= cmd_reset;
    end
    else
    begin
      case (state)
        st_idle:
        begin
          if (q_valid)
          begin
            cur <= swu_cmd_e'(q_data);
            if (swu_cmd_e'(q_data) == cmd_power)
            begin
              state <= st_power;
            end
            else
            begin
              state <= st_frame;
            end
          end
        end
        st_frame:
        begin
          if (baud_tick && bits_left == 4'h1)
          begin
            state <= st_idle;
          end
        end
        st_power:
        begin
          if (por_cnt == 20'h00001)
          begin
            state <= st_idle;
          end
        end
        default:
        begin
          state <= st_idle;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  assign baud_tick = (state == st_frame) && (baud_cnt == 8'h00);

  always_ff @(posedge sys_clk)
  begin
    if (rst || state != st_frame || baud_cnt == 8'h00)
    begin
      baud_cnt <= BIT_LAST;
    end
    else
    begin
      baud_cnt <= baud_cnt - 8'h01;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tx_sh     <= 10'h3ff;
      bits_left <= 4'h0;
    end
    else if (state == st_idle && q_valid)
    begin
      bits_left <= `SWU_FRAME_BITS;
      case (swu_cmd_e'(q_data))
        cmd_reset:  tx_sh <= {1'b1, `SWU_BYTE_RESET, 1'b0};
        cmd_write0: tx_sh <= {1'b1, `SWU_BYTE_ZERO, 1'b0};
        cmd_write1: tx_sh <= {1'b1, `SWU_BYTE_ONE, 1'b0};
        cmd_read:   tx_sh <= {1'b1, `SWU_BYTE_ONE, 1'b0};
        default:    tx_sh <= 10'h3ff;
      endcase
    end
    else if (baud_tick)
    begin
      tx_sh     <= {1'b1, tx_sh[9:1]};
      bits_left <= bits_left - 4'h1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      por_cnt <= 20'h00000;
    end
    else if (state == st_idle && q_valid)
    begin
      por_cnt <= 20'(POR_CYC);
    end
    else if (state == st_power)
    begin
      por_cnt <= por_cnt - 20'h00001;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tx_level <= 1'b1;
    end
    else if (state == st_frame)
    begin
      tx_level <= tx_sh[0];
    end
    else
    begin
      tx_level <= (state != st_power);
    end
  end

  // The open-drain buffer only ever pulls low.
  assign bus.host_out = 1'b0;
  assign bus.host_oe  = !tx_level;

  // ----------------------------------------------------------------
  // Echo receiver
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      line_m <= 1'b1;
      line_s <= 1'b1;
      line_d <= 1'b1;
    end
    else
    begin
      line_m <= bus.shared_data_line;
      line_s <= line_m;
      line_d <= line_s;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rx_busy <= 1'b0;
      rx_cnt  <= 8'h00;
      rx_idx  <= 4'h0;
      rx_sh   <= 9'h000;
    end
    else if (!rx_busy)
    begin
      if (line_d && !line_s)
      begin
        rx_busy <= 1'b1;
        rx_cnt  <= BIT_HALF;
        rx_idx  <= 4'h0;
      end
    end
    else if (rx_cnt != 8'h00)
    begin
      rx_cnt <= rx_cnt - 8'h01;
    end
    else
    begin
      rx_cnt <= BIT_LAST;
      rx_sh  <= {line_s, rx_sh[8:1]};
      rx_idx <= rx_idx + 4'h1;
      if (rx_idx == 4'h8)
      begin
        rx_busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst || (state == st_idle && q_valid))
    begin
      echo      <= 8'h00;
      echo_seen <= 1'b0;
    end
    else if (rx_busy && rx_cnt == 8'h00 && rx_idx == 4'h8)
    begin
      echo      <= {line_s, rx_sh[8:2]};
      echo_seen <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Result
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      done     <= 1'b0;
      rd_valid <= 1'b0;
      rd_bit   <= 1'b0;
      rd_err   <= 1'b0;
    end
    else
    begin
      done     <= (state == st_frame && baud_tick && bits_left == 4'h1) ||
                  (state == st_power && por_cnt == 20'h00001);
      rd_valid <= 1'b0;
      // Echoes of writes and resets are dropped here.
      if (state == st_frame && baud_tick && bits_left == 4'h1 && cur == cmd_read)
      begin
        rd_valid <= 1'b1;
        rd_bit   <= echo_seen && echo == `SWU_ECHO_ONE;
        rd_err   <= !echo_seen ||
                    (echo != `SWU_ECHO_ONE && echo != `SWU_ECHO_ZERO);
      end
    end
  end
endmodule
`default_nettype wire

// [swu_chk_sva.sv]
// Checker for the shared data line between the host and sensor ends.
`timescale 1ns/1ns
`default_nettype none
module swu_chk #(
  parameter int POR_CYC = 1000000
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic host_out,
  input wire logic host_oe,
  input wire logic dev_out,
  input wire logic dev_oe,
  input wire logic shared_data_line
);
  // --------------------------------------------------------------
  // Drive-time counters
  // --------------------------------------------------------------
  logic [31:0] host_cnt;
  logic [31:0] dev_cnt;

  always_ff @(posedge sys_clk)
  begin
    if (rst || !host_oe)
      host_cnt <= 32'h0;
    else
      host_cnt <= host_cnt + 32'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst || !dev_oe)
      dev_cnt <= 32'h0;
    else
      dev_cnt <= dev_cnt + 32'h1;
  end

  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  host_low_only_a: assert property (host_oe |-> !host_out)
    else $error("host drives the line high");
  dev_low_only_a: assert property (dev_oe |-> !dev_out)
    else $error("sensor drives the line high");
  idle_release_a: assert property ($fell(rst) |-> !host_oe && !dev_oe)
    else $error("line driven just after reset");
  dev_after_host_a: assert property ($rose(dev_oe) |-> host_oe && $past(host_oe, 2))
    else $error("sensor drives without a host slot");
  dev_sees_low_a: assert property ($rose(dev_oe) |-> !$past(shared_data_line))
    else $error("sensor drives before line fell");
  dev_hold_len_a: assert property ($fell(dev_oe) |-> dev_cnt == 32'd1000)
    else $error("sensor zero hold has wrong length");
  slot_len_a: assert property ($fell(host_oe) && host_cnt <= 32'd1800 |->
    host_cnt inside {32'd200, 32'd1400, 32'd1800})
    else $error("host slot low time wrong");
  power_len_a: assert property ($fell(host_oe) && host_cnt > 32'd1800 |->
    host_cnt >= POR_CYC)
    else $error("host power reset too short");
  host_release_a: assert property ($fell(host_oe) && dev_cnt == 32'h0 |=> shared_data_line)
    else $error("line not high after release");

  cover property ($fell(dev_oe));
  cover property ($fell(host_oe) && host_cnt >= POR_CYC);
  cover property ($fell(host_oe) && host_cnt == 32'd1400);
endmodule
`default_nettype wire

// [test_single_wire_uart_bit_mapper.sv]
// Testbench joining the host and sensor ends over the shared data line.
`timescale 1ns/1ns
`default_nettype none
module test_single_wire_uart_bit_mapper;
  import swu_pkg::*;
  localparam int POR = 2000;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cmd_valid = 1'b0, cmd_ready, busy, done, rd_valid, rd_bit, rd_err;
  swu_cmd_e    cmd = cmd_reset;
  logic        tx_valid = 1'b0, tx_bit = 1'b0, tx_ready, ev_valid;
  swu_kind_e   ev_kind, last_kind;
  logic        b_valid = 1'b0, b_ready, b_done, b_rdv, b_bit, b_err, b_hold = 1'b0;
  logic [31:0] low_cnt = 0, last_low = 0, dn = 0, rd_n = 0, n_mismatch = 0, num_checks = 0;
  int          i, j, k;

  swu_if bus_if();
  swu_if bad_if();
  assign bad_if.dev_out = 1'b0;
  assign bad_if.dev_oe = b_hold;

  swu_host #(.POR_CYC(POR)) swu_host_inst (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .bus(bus_if.host), .busy(busy), .done(done),
    .rd_valid(rd_valid), .rd_bit(rd_bit), .rd_err(rd_err));
  swu_device swu_device_inst (.sys_clk(sys_clk), .rst(rst), .bus(bus_if.device),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_bit(tx_bit), .ev_valid(ev_valid),
    .ev_kind(ev_kind));
  swu_host #(.POR_CYC(POR)) swu_host_err_inst (.sys_clk(sys_clk), .rst(rst), .cmd_valid(b_valid),
    .cmd_ready(b_ready), .cmd(cmd_read), .bus(bad_if.host), .busy(), .done(b_done),
    .rd_valid(b_rdv), .rd_bit(b_bit), .rd_err(b_err));
  swu_chk #(.POR_CYC(POR)) swu_chk_inst (.sys_clk(sys_clk), .rst(rst),
    .host_out(bus_if.host_out), .host_oe(bus_if.host_oe), .dev_out(bus_if.dev_out),
    .dev_oe(bus_if.dev_oe), .shared_data_line(bus_if.shared_data_line));

  always #25 sys_clk = ~sys_clk;

  // --------------------------------------------------------------
  // Line and event monitor
  // --------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (bus_if.shared_data_line !== 1'b1)
      low_cnt <= low_cnt + 1;
    else
    begin
      if (low_cnt != 0)
        last_low <= low_cnt;
      low_cnt <= 0;
    end
    if (ev_valid === 1'b1)
      last_kind <= ev_kind;
    if (done === 1'b1)
      dn <= dn + 1;
    if (rd_valid === 1'b1)
      rd_n <= rd_n + 1;
  end

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick();
    @(posedge sys_clk);
    #2;
  endtask

  task automatic bail();
    n_mismatch++;
    $display("wrong value at %0t got %h exp %h", $time, 0, 1);
    wrap_up();
  endtask

  task automatic push(input swu_cmd_e c);
    for (i = 0; i < 50000 && cmd_ready !== 1'b1; i++)
      tick();
    if (cmd_ready !== 1'b1)
      bail();
    cmd_valid = 1'b1;
    cmd = c;
    tick();
    cmd_valid = 1'b0;
    tick();
  endtask

  task automatic wait_n(input logic [31:0] n);
    for (i = 0; i < 50000 && dn < n; i++)
      tick();
    if (dn < n)
      bail();
  endtask

  task automatic arm(input logic b);
    for (i = 0; i < 100 && tx_ready !== 1'b1; i++)
      tick();
    if (tx_ready !== 1'b1)
      bail();
    tx_valid = 1'b1;
    tx_bit = b;
    tick();
    tx_valid = 1'b0;
  endtask

  task automatic run(input string nm, input swu_cmd_e c, input logic [31:0] exp_low,
                     input swu_kind_e kd);
    push(c);
    wait_n(dn + 1);
    repeat (6) tick();
    if (exp_low != 0)
      chk(last_low, exp_low);
    chk({30'h0, last_kind}, {30'h0, kd});
    chk({31'h0, bus_if.shared_data_line}, 32'h1);
    $display("test %s done", nm);
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial
  begin
    repeat (2) tick();
    rst = 1'b0;
    chk({cmd_ready, tx_ready, bus_if.shared_data_line}, 32'h7);
    run("reset", cmd_reset, 32'd1800, kind_reset);
    run("write one", cmd_write1, 32'd200, kind_one);
    run("write zero", cmd_write0, 32'd1400, kind_zero);
    arm(1'b0);
    run("read zero", cmd_read, 32'd0, kind_read);
    chk({rd_bit, rd_err}, 32'h0);
    arm(1'b1);
    run("read one", cmd_read, 32'd200, kind_read);
    chk({rd_bit, rd_err}, 32'h2);
    run("power", cmd_power, POR, kind_reset);
    push(cmd_write1);
    push(cmd_write0);
    push(cmd_reset);
    wait_n(dn + 3);
    repeat (6) tick();
    chk(last_low, 32'd1800);
    chk({30'h0, last_kind}, {30'h0, kind_reset});
    chk(rd_n, 32'd2);
    $display("test back to back done");
    b_valid = 1'b1;
    tick();
    b_valid = 1'b0;
    for (i = 0; i < 100 && bad_if.host_oe !== 1'b1; i++)
      tick();
    if (bad_if.host_oe !== 1'b1)
      bail();
    b_hold = 1'b1;
    repeat (400) tick();
    b_hold = 1'b0;
    for (i = 0; i < 5000 && b_rdv !== 1'b1; i++)
      tick();
    chk({29'h0, b_rdv, b_bit, b_err}, 32'h5);
    $display("test bad echo done");
    j = dn;
    for (k = 0; k < 17; k++)
    begin
      if (k == 16)
        chk({31'h0, cmd_ready}, 32'h1);
      push((k == 16) ? cmd_reset : cmd_write1);
    end
    chk({30'h0, cmd_ready, busy}, 32'h1);
    wait_n(j + 17);
    repeat (6) tick();
    chk({30'h0, cmd_ready, busy}, 32'h2);
    chk(dn, j + 17);
    chk(last_low, 32'd1800);
    chk({30'h0, last_kind}, {30'h0, kind_reset});
    chk(rd_n, 32'd2);
    $display("test buffer done");
    wrap_up();
  end
endmodule
`default_nettype wire
